// file: hw/mvaf_filter.sv
// two-channel measured value averaging filter with wishbone registers
// Behaviour
// - each channel selects pass-through, moving average, recursive average or median.
// - moving average outputs the mean of the latest N consecutive measured values.
// - each new value enters the moving window and, once it is full, the oldest leaves, one sample per step.
// - the moving window width is a power of two so the division is a right shift.
// - the moving window reaches 512 samples and the history memory holds that many.
// - recursive output is the new value plus N-1 times the previous output, over N.
// - the recursive weight N ranges from 1 to 32768.
// - the median window width is limited to the range of 3 to 9 samples.
// - after each median sample the window is ranked and the middle element output.
// - an even median width outputs half the sum of the two central values.
// - each channel has a laser enable that follows its setting.
`timescale 1ns/100ps
`default_nettype none
module mvaf_filter (
  // clock and reset
  input  wire logic                                   clk_i,
  input  wire logic                                   rst_i,
  // wishbone slave
  input  wire logic                                   wb_cyc_i,
  input  wire logic                                   wb_stb_i,
  input  wire logic                                   wb_we_i,
  input  wire logic [7:0]                             wb_adr_i,
  input  wire logic [3:0]                             wb_sel_i,
  input  wire logic [31:0]                            wb_dat_i,
  output var  logic [31:0]                            wb_dat_o,
  output var  logic                                   wb_ack_o,
  // measured value streams
  input  wire mvaf_pkg::mvaf_mv_s [mvaf_pkg::CH_N-1:0] mv_in_i,
  output wire logic [mvaf_pkg::CH_N-1:0]              mv_ready_o,
  output wire mvaf_pkg::mvaf_mv_s [mvaf_pkg::CH_N-1:0] mv_out_o,
  // sensor control
  output var  logic [mvaf_pkg::CH_N-1:0]              laser_on_o
);
  import mvaf_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge_f(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r & CTRL_MASK;
  endfunction

  // highest set bit, so any nonzero width snaps down to a power of two
  function automatic logic [3:0] ma_log2_f(input logic [REC_W-1:0] w);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < REC_W; i++) begin
      if (w[i]) begin
        r = (i > MA_LOG2_MAX) ? 4'(MA_LOG2_MAX) : 4'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [3:0] med_w_f(input logic [REC_W-1:0] w);
    logic [3:0] r;
    if (w < REC_W'(MED_MIN)) begin
      r = 4'(MED_MIN);
    end else if (w > REC_W'(MED_MAX)) begin
      r = 4'(MED_MAX);
    end else begin
      r = w[3:0];
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  logic              req;
  logic [31:0]       ctrl   [CH_N];
  logic [31:0]       merged [CH_N];
  logic [CH_N-1:0]   wr_hit;
  logic [CH_N-1:0]   wr_chg;
  logic [CH_N-1:0]   clr_req;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_comb begin
    for (int c = 0; c < CH_N; c++) begin
      merged[c] = merge_f(ctrl[c], wb_dat_i, wb_sel_i);
      wr_hit[c] = req && wb_we_i && (wb_adr_i == ADDR_CTRL_BASE + 8'(c) * ADDR_STRIDE);
      wr_chg[c] = wr_hit[c] &&
                  ((merged[c][CTRL_MODE_LSB +: 2] != ctrl[c][CTRL_MODE_LSB +: 2]) ||
                   (merged[c][CTRL_WIDTH_LSB +: REC_W] != ctrl[c][CTRL_WIDTH_LSB +: REC_W]));
    end
  end

  // single-cycle answer; unmapped addresses are acked, read zero and ignore writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= 32'h00000000;
      for (int c = 0; c < CH_N; c++) begin
        if (wb_adr_i == ADDR_CTRL_BASE + 8'(c) * ADDR_STRIDE) begin
          wb_dat_o <= ctrl[c];
        end
        if (wb_adr_i == ADDR_RES_BASE + 8'(c) * ADDR_STRIDE) begin
          wb_dat_o <= {15'h0000, !mv_ready_o[c], mv_out_o[c].value};
        end
      end
    end
  end

  // settings are per channel, and a changed mode or width triggers that channel's clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int c = 0; c < CH_N; c++) begin
        ctrl[c] <= CTRL_RESET;
      end
      clr_req    <= '0;
      laser_on_o <= '0;
    end else begin
      clr_req <= wr_chg;
      for (int c = 0; c < CH_N; c++) begin
        if (wr_hit[c]) begin
          ctrl[c] <= merged[c];
        end
        laser_on_o[c] <= ctrl[c][CTRL_LASER_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // filter channels
  // ----------------------------------------------------------------
  for (genvar c = 0; c < CH_N; c++) begin : g_ch
    mvaf_mode_e        mode;
    mvaf_state_e       state;
    mvaf_state_e       next_state;
    mvaf_mv_s          out_q;
    logic              ready_q;
    logic              take;
    logic              clr;
    logic              full;
    logic [REC_W-1:0]  width;
    logic [REC_W-1:0]  rec_n;
    logic [3:0]        ma_log2;
    logic [3:0]        med_w;
    logic [3:0]        n_eff;
    logic [3:0]        k_lo;
    logic [3:0]        k_hi;
    logic [HIST_AW:0]  ma_n;
    logic [HIST_AW:0]  fill;
    logic [HIST_AW-1:0] ptr;
    logic [MV_W-1:0]   new_val;
    logic [MV_W-1:0]   old_val;
    logic [MV_W-1:0]   prev;
    logic [MV_W-1:0]   lo;
    logic [MV_W-1:0]   hi;
    logic [MV_W-1:0]   med_val;
    logic [MV_W-1:0]   med_q [MED_MAX];
    logic [3:0]        rank  [MED_MAX];
    logic [SUM_W-1:0]  sum;
    logic [SUM_W-1:0]  next_sum;
    logic [ACC_W-1:0]  quo;
    logic [ACC_W-1:0]  next_quo;
    logic [REC_W:0]    rem;
    logic [REC_W:0]    rem_sh;
    logic [REC_W:0]    next_rem;
    logic [4:0]        dcnt;

    assign clr     = clr_req[c];
    assign mode    = mvaf_mode_e'(ctrl[c][CTRL_MODE_LSB +: 2]);
    assign width   = ctrl[c][CTRL_WIDTH_LSB +: REC_W];
    assign ma_log2 = ma_log2_f(width);
    assign ma_n    = (HIST_AW+1)'(1) << ma_log2;
    assign med_w   = med_w_f(width);
    assign rec_n   = (width == '0) ? REC_W'(1) : ((width > REC_MAX) ? REC_MAX : width);
    assign take    = ready_q && mv_in_i[c].valid;
    assign full    = fill > ma_n;

    assign mv_out_o[c]   = out_q;
    assign mv_ready_o[c] = ready_q;

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    always_comb begin
      next_state = state;
      case (state)
        ST_IDLE: begin
          if (take) begin
            case (mode)
              MODE_MOVING:    next_state = ST_READ;
              MODE_MEDIAN:    next_state = ST_UPDATE;
              MODE_RECURSIVE: next_state = (fill != '0) ? ST_DIVIDE : ST_IDLE;
              default:        next_state = ST_IDLE;
            endcase
          end
        end
        ST_READ:   next_state = ST_IDLE;
        ST_UPDATE: next_state = ST_IDLE;
        ST_DIVIDE: next_state = (dcnt == DIV_LAST) ? ST_IDLE : ST_DIVIDE;
        default:   next_state = ST_IDLE;
      endcase
    end

    always_ff @(posedge clk_i) begin
      if (rst_i || clr) begin
        state <= ST_IDLE;
      end else begin
        state <= next_state;
      end
    end

    // ready drops for the clear cycle so no sample is swallowed by it
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ready_q <= 1'b0;
      end else begin
        ready_q <= (clr || next_state == ST_IDLE) && !wr_chg[c];
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i || clr) begin
        fill <= '0;
        ptr  <= '0;
      end else begin
        if (take && fill != '1) begin
          fill <= fill + (HIST_AW+1)'(1);
        end
        if (state == ST_READ) begin
          ptr <= ptr + HIST_AW'(1);
        end
      end
    end

    // ---------------------------------------------------------------
    // moving average: running sum over a circular history
    // ---------------------------------------------------------------
    mvaf_hist_mem #(
      .AW (HIST_AW),
      .DW (MV_W)
    ) u_hist (
      .clk_i     (clk_i),
      .we_i      (state == ST_READ),
      .wr_addr_i (ptr),
      .wr_data_i (new_val),
      .rd_addr_i (ptr - ma_n[HIST_AW-1:0]),
      .rd_data_o (old_val)
    );

    // the oldest word only leaves once the window is really full
    assign next_sum = sum + SUM_W'(new_val) - (full ? SUM_W'(old_val) : SUM_W'(0));

    always_ff @(posedge clk_i) begin
      if (rst_i || clr) begin
        sum <= '0;
      end else if (state == ST_READ) begin
        sum <= next_sum;
      end
    end

    // ---------------------------------------------------------------
    // median: shift window and rank by magnitude
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
      if (take) begin
        new_val  <= mv_in_i[c].value;
        med_q[0] <= mv_in_i[c].value;
        for (int i = 1; i < MED_MAX; i++) begin
          med_q[i] <= med_q[i-1];
        end
      end
    end

    assign n_eff = (fill >= (HIST_AW+1)'(med_w)) ? med_w : fill[3:0];
    assign k_lo  = (n_eff - 4'h1) >> 1;
    assign k_hi  = n_eff >> 1;

    // ties rank by age, so every rank is unique and sorting needs no swap network
    always_comb begin
      for (int i = 0; i < MED_MAX; i++) begin
        rank[i] = 4'h0;
        for (int j = 0; j < MED_MAX; j++) begin
          if (4'(j) < n_eff && (med_q[j] < med_q[i] || (med_q[j] == med_q[i] && j < i))) begin
            rank[i] = rank[i] + 4'h1;
          end
        end
      end
    end

    always_comb begin
      lo = '0;
      hi = '0;
      for (int i = 0; i < MED_MAX; i++) begin
        if (4'(i) < n_eff && rank[i] == k_lo) begin
          lo = med_q[i];
        end
        if (4'(i) < n_eff && rank[i] == k_hi) begin
          hi = med_q[i];
        end
      end
      med_val = MV_W'(((MV_W+1)'(lo) + (MV_W+1)'(hi)) >> 1);
    end

    // ---------------------------------------------------------------
    // recursive average: serial divider, 32 steps per sample
    // ---------------------------------------------------------------
    assign rem_sh   = {rem[REC_W-1:0], quo[ACC_W-1]};
    assign next_rem = (rem_sh >= {1'b0, rec_n}) ? rem_sh - {1'b0, rec_n} : rem_sh;
    assign next_quo = {quo[ACC_W-2:0], rem_sh >= {1'b0, rec_n}};

    always_ff @(posedge clk_i) begin
      if (rst_i || clr) begin
        quo  <= '0;
        rem  <= '0;
        dcnt <= '0;
      end else if (take && mode == MODE_RECURSIVE) begin
        quo  <= ACC_W'(mv_in_i[c].value) + ACC_W'(rec_n - REC_W'(1)) * ACC_W'(prev);
        rem  <= '0;
        dcnt <= '0;
      end else if (state == ST_DIVIDE) begin
        quo  <= next_quo;
        rem  <= next_rem;
        dcnt <= dcnt + 5'h01;
      end
    end

    // ---------------------------------------------------------------
    // result
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
      if (rst_i || clr) begin
        out_q <= '0;
        prev  <= '0;
      end else begin
        out_q.valid <= 1'b0;
        if (take && mode == MODE_NONE) begin
          out_q <= {1'b1, mv_in_i[c].value};
        end
        if (take && mode == MODE_RECURSIVE && fill == '0) begin
          out_q <= {1'b1, mv_in_i[c].value};
          prev  <= mv_in_i[c].value;
        end
        if (state == ST_READ) begin
          out_q <= {1'b1, MV_W'(next_sum >> ma_log2)};
        end
        if (state == ST_UPDATE) begin
          out_q <= {1'b1, med_val};
        end
        if (state == ST_DIVIDE && dcnt == DIV_LAST) begin
          out_q <= {1'b1, next_quo[MV_W-1:0]};
          prev  <= next_quo[MV_W-1:0];
        end
      end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence s_take_mode(mvaf_mode_e m);
      take && mode == m;
    endsequence

    sequence s_result;
      out_q.valid;
    endsequence

    AST_PASS_THROUGH: assert property (@(posedge clk_i) disable iff (rst_i || clr)
      s_take_mode(MODE_NONE) |=> s_result and out_q.value == $past(mv_in_i[c].value))
      else $error("pass-through result missing or altered");

    AST_MA_UNIT_WIDTH: assert property (@(posedge clk_i) disable iff (rst_i || clr)
      s_take_mode(MODE_MOVING) && ma_log2 == 4'h0 |->
        ##2 s_result and out_q.value == $past(mv_in_i[c].value, 2))
      else $error("moving average of width one differs from input");

    AST_MA_SLIDE: assert property (@(posedge clk_i) disable iff (rst_i || clr)
      s_take_mode(MODE_MOVING) |-> ##1 state == ST_READ ##1 s_result and
        ptr == $past(ptr, 2) + HIST_AW'(1))
      else $error("moving window did not slide by one");

    AST_MA_POW2: assert property (@(posedge clk_i) disable iff (rst_i)
      $onehot(ma_n))
      else $error("moving width not a power of two");

    AST_MA_MAX: assert property (@(posedge clk_i) disable iff (rst_i)
      width[REC_W-1:MA_LOG2_MAX+1] != '0 |-> ma_n == (HIST_AW+1)'(1) << MA_LOG2_MAX)
      else $error("large moving width not held at maximum");

    AST_REC_UNIT: assert property (@(posedge clk_i) disable iff (rst_i || clr)
      s_take_mode(MODE_RECURSIVE) && fill != '0 && rec_n == REC_W'(1) |->
        ##33 s_result and out_q.value == $past(mv_in_i[c].value, 33))
      else $error("recursive result of weight one differs from input");

    AST_REC_RANGE: assert property (@(posedge clk_i) disable iff (rst_i)
      rec_n != '0 && rec_n <= REC_MAX)
      else $error("recursive weight out of range");

    AST_MED_RANGE: assert property (@(posedge clk_i) disable iff (rst_i)
      med_w >= 4'(MED_MIN) && med_w <= 4'(MED_MAX))
      else $error("median width out of range");

    AST_MED_ORDER: assert property (@(posedge clk_i) disable iff (rst_i || clr)
      s_take_mode(MODE_MEDIAN) |-> ##1 (state == ST_UPDATE && lo <= hi) ##1 s_result)
      else $error("median central values out of order or late");

    AST_LASER: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(ctrl[c][CTRL_LASER_BIT]) |=> laser_on_o[c])
      else $error("laser enable did not follow setting");

    AST_OWN_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
      clr |-> $past(wr_chg[c]) ##1 (fill == '0 && sum == '0 && !out_q.valid))
      else $error("channel history not cleared by own change");
  end
endmodule
`default_nettype wire

// file: hw/mvaf_hist_mem.sv
// history memory of one channel, registered read port
`timescale 1ns/100ps
`default_nettype none
module mvaf_hist_mem #(
  parameter int AW = 9,
  parameter int DW = 16
) (
  // clock
  input  wire logic          clk_i,
  // write port
  input  wire logic          we_i,
  input  wire logic [AW-1:0] wr_addr_i,
  input  wire logic [DW-1:0] wr_data_i,
  // read port
  input  wire logic [AW-1:0] rd_addr_i,
  output var  logic [DW-1:0] rd_data_o
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // contents are never cleared; the caller masks stale words by its fill count
  always_ff @(posedge clk_i) begin
    rd_data_o <= mem[rd_addr_i];
  end
endmodule
`default_nettype wire

// file: hw/mvaf_pkg.sv
// constants and types of the measured value averaging filter
package mvaf_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int MV_W    = 16;
  localparam int CH_N    = 2;
  localparam int HIST_AW = 9;
  localparam int SUM_W   = MV_W + HIST_AW;
  localparam int MA_LOG2_MAX = 9;
  localparam int MED_MIN = 3;
  localparam int MED_MAX = 9;
  localparam int REC_W   = 16;
  localparam int ACC_W   = 32;
  localparam logic [REC_W-1:0] REC_MAX = 16'h8000;
  localparam logic [4:0]       DIV_LAST = 5'h1F;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL_BASE = 8'h00;
  localparam logic [7:0]  ADDR_RES_BASE  = 8'h08;
  localparam logic [7:0]  ADDR_STRIDE    = 8'h04;
  localparam int          CTRL_MODE_LSB  = 0;
  localparam int          CTRL_LASER_BIT = 4;
  localparam int          CTRL_WIDTH_LSB = 16;
  localparam int          RES_BUSY_BIT   = 16;
  localparam logic [31:0] CTRL_MASK      = 32'hFFFF0013;
  localparam logic [31:0] CTRL_RESET     = 32'h00000000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_NONE,
    MODE_MOVING,
    MODE_RECURSIVE,
    MODE_MEDIAN
  } mvaf_mode_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_UPDATE,
    ST_DIVIDE
  } mvaf_state_e;

  typedef struct packed {
    logic            valid;
    logic [MV_W-1:0] value;
  } mvaf_mv_s;
endpackage

// file: test/mvaf_sensor_model.sv
// behavioural distance sensor that offers one measured value at a time
`timescale 1ns/100ps
`default_nettype none
module mvaf_sensor_model (
  // clock
  input  wire logic               clk_i,
  // stream toward the filter
  input  wire logic               ready_i,
  output var  mvaf_pkg::mvaf_mv_s mv_o
);
  import mvaf_pkg::*;

  initial mv_o = '0;

  // ----------------------------------------------------------------
  // transfer
  // ----------------------------------------------------------------
  // the value line is not held after a transfer: its inverse exposes stale sampling
  task automatic send(input logic [MV_W-1:0] v, input int gap);
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    mv_o <= {1'b1, v};
    do @(posedge clk_i); while (ready_i !== 1'b1);
    mv_o <= {1'b0, ~v};
  endtask
endmodule
`default_nettype wire

// file: test/tb_top.sv
// self-checking bench of the two-channel averaging filter
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import mvaf_pkg::*;

  // ----------------------------------------------------------------
  // stimulus and observation
  // ----------------------------------------------------------------
  logic                    clk_i  = 1'b0;
  logic                    rst_i  = 1'b1;
  logic                    wb_cyc = 1'b0;
  logic                    wb_stb = 1'b0;
  logic                    wb_we  = 1'b0;
  logic [7:0]              wb_adr = '0;
  logic [3:0]              wb_sel = '0;
  logic [31:0]             wb_dat = '0;
  logic [31:0]             wb_rdat;
  logic                    wb_ack;
  wire  mvaf_mv_s [CH_N-1:0] mv_in;
  wire  mvaf_mv_s [CH_N-1:0] mv_out;
  wire  logic [CH_N-1:0]   mv_ready;
  logic [CH_N-1:0]         laser_on;
  int                      mismatches  = 0;
  int                      check_count = 0;
  int                      mode_c[CH_N];
  int                      wid_c[CH_N];
  longint                  prev_c[CH_N];
  int                      hist[CH_N][$];
  logic [MV_W-1:0]         outq[CH_N][$];
  logic [31:0]             rd;
  int                      med5[6] = '{2, 4, 5, 1, 3, 5};
  int                      med4[5] = '{1, 9, 3, 7, 20};

  always #20 clk_i = ~clk_i;

  mvaf_filter mvaf_filter_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .mv_in_i(mv_in), .mv_ready_o(mv_ready), .mv_out_o(mv_out),
    .laser_on_o(laser_on));
  mvaf_sensor_model sens0_i (.clk_i(clk_i), .ready_i(mv_ready[0]), .mv_o(mv_in[0]));
  mvaf_sensor_model sens1_i (.clk_i(clk_i), .ready_i(mv_ready[1]), .mv_o(mv_in[1]));

  // results are single-cycle pulses, so they are collected at every edge
  always @(posedge clk_i)
    for (int c = 0; c < CH_N; c++)
      if (mv_out[c].valid === 1'b1) outq[c].push_back(mv_out[c].value);

  // ----------------------------------------------------------------
  // compare and closing
  // ----------------------------------------------------------------
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // wishbone master
  // ----------------------------------------------------------------
  task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [3:0] s,
                          input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= a;
    wb_sel <= s;
    wb_dat <= d;
    // the ack ends this wait; only the watchdog ends it if no ack comes
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
    chk_bit("wb_ack", 1'b0, wb_ack);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb_cycle(1'b0, a, 4'hF, 32'h0, rd);
    chk_word(nm, e, rd);
  endtask

  // a mode or width write clears the channel, so the model history restarts too
  task automatic cfg(input int c, input int md, input int ww, input int ew, input logic lz);
    wb_cycle(1'b1, ADDR_CTRL_BASE + 8'(c) * ADDR_STRIDE, 4'hF,
             {16'(ww), 11'h0, lz, 2'h0, 2'(md)}, rd);
    mode_c[c] = md;
    wid_c[c] = ew;
    hist[c].delete();
    @(posedge clk_i);
    chk_bit("laser_on", lz, laser_on[c]);
  endtask

  // ----------------------------------------------------------------
  // reference model and sample transfer
  // ----------------------------------------------------------------
  function automatic int expect_out(input int c, input int x);
    int k;
    int s;
    int w[$];
    hist[c].push_back(x);
    k = hist[c].size();
    case (mode_c[c])
      0: return x;
      1: begin
        s = 0;
        for (int i = k - 1; i >= 0 && i >= k - wid_c[c]; i--) s += hist[c][i];
        return s / wid_c[c];
      end
      2: begin
        prev_c[c] = (k == 1) ? x : (x + (wid_c[c] - 1) * prev_c[c]) / wid_c[c];
        return int'(prev_c[c]);
      end
      default: begin
        for (int i = k - 1; i >= 0 && i >= k - wid_c[c]; i--) w.push_back(hist[c][i]);
        w.sort();
        s = w.size();
        return (s % 2) ? w[s / 2] : (w[s / 2 - 1] + w[s / 2]) / 2;
      end
    endcase
  endfunction

  task automatic sample(input int c, input int x, input int gap);
    int e;
    int n;
    logic er;
    e = expect_out(c, x);
    er = (mode_c[c] == 0) || (mode_c[c] == 2 && hist[c].size() == 1);
    n = 0;
    if (c == 0) sens0_i.send(16'(x), gap);
    else sens1_i.send(16'(x), gap);
    // ready in the cycle after the take: only single-step results keep it up
    @(posedge clk_i);
    chk_bit("mv_ready", er, mv_ready[c]);
    while (outq[c].size() == 0 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    chk_word("mv_out", 32'(e), (outq[c].size() > 0) ? 32'(outq[c].pop_front()) : 32'hX);
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("ctrl0", ADDR_CTRL_BASE, CTRL_RESET);
    rd_chk("res1", ADDR_RES_BASE + ADDR_STRIDE, 32'h0);
    rd_chk("unmapped", 8'h40, 32'h0);
    wb_cycle(1'b1, ADDR_RES_BASE, 4'hF, 32'hFFFFFFFF, rd);
    rd_chk("res0 ro", ADDR_RES_BASE, 32'h0);
    wb_cycle(1'b1, ADDR_CTRL_BASE + ADDR_STRIDE, 4'hF, 32'hFFFFFFFF, rd);
    rd_chk("ctrl1 mask", ADDR_CTRL_BASE + ADDR_STRIDE, CTRL_MASK);
    wb_cycle(1'b1, ADDR_CTRL_BASE, 4'h1, 32'hFFFFFFFF, rd);
    rd_chk("ctrl0 sel", ADDR_CTRL_BASE, 32'h00000013);
    cfg(0, 0, 0, 1, 1'b0);
    cfg(1, 0, 0, 1, 1'b1);
    for (int i = 0; i < 3; i++) sample(0, 16'hFFF0 + i, 0);
    cfg(0, 1, 5, 4, 1'b1);
    cfg(1, 2, 4, 4, 1'b0);
    sample(0, 2, 0);
    sample(1, 100, 3);
    sample(0, 2, 0);
    sample(1, 200, 0);
    sample(0, 1, 2);
    sample(1, 0, 0);
    sample(0, 3, 0);
    sample(0, 4, 0);
    rd_chk("res0", ADDR_RES_BASE, 32'h2);
    cfg(0, 3, 5, 5, 1'b0);
    rd_chk("res0 cleared", ADDR_RES_BASE, 32'h0);
    foreach (med5[i]) sample(0, med5[i], 0);
    cfg(0, 3, 4, 4, 1'b0);
    foreach (med4[i]) sample(0, med4[i], 1);
    cfg(0, 3, 9, 9, 1'b0);
    for (int i = 0; i < 11; i++) sample(0, (i * 37) % 50, 0);
    cfg(1, 2, 40000, 32768, 1'b0);
    sample(1, 1000, 0);
    sample(1, 0, 0);
    cfg(1, 2, 0, 1, 1'b0);
    for (int i = 0; i < 3; i++) sample(1, 16'h0100 + 16'h0300 * i, 0);
    cfg(0, 1, 1, 1, 1'b0);
    for (int i = 0; i < 3; i++) sample(0, 16'h1234 * i, 0);
    cfg(0, 1, 1000, 512, 1'b1);
    for (int i = 0; i < 600; i++) sample(0, (i * 211) % 65536, 0);
    end_sim();
  end
endmodule
`default_nettype wire
